// ---- logic/tcsb_pkg.sv ----
// Shared constants, types and helpers of the confirmation status byte block
package tcsb_pkg;

   // Register word indexes on the Avalon-MM slave
   localparam logic [2:0] TCSB_REG_MODE       = 3'h0;
   localparam logic [2:0] TCSB_REG_EXP_STATUS = 3'h1;
   localparam logic [2:0] TCSB_REG_CONFIRM    = 3'h2;
   localparam logic [2:0] TCSB_REG_ATTENTION  = 3'h3;
   localparam logic [2:0] TCSB_REG_INT_STATUS = 3'h4;
   localparam logic [2:0] TCSB_REG_INT_MASK   = 3'h5;

   // Field positions
   localparam int TCSB_MODE_THRU_PARITY = 0;
   localparam int TCSB_CS_KIND_LSB      = 0;
   localparam int TCSB_CS_FULL          = 2;
   localparam int TCSB_CS_UNEXP         = 3;
   localparam int TCSB_CS_PARITY        = 4;
   localparam int TCSB_CS_EXC           = 5;
   localparam int TCSB_CS_RINGOP        = 6;
   localparam int TCSB_CONFIRM_BUSY     = 8;
   localparam int TCSB_INT_DONE         = 0;
   localparam int TCSB_INT_EXC          = 1;

   // Reset values
   localparam logic [7:0] TCSB_MODE_RST       = 8'h00;
   localparam logic [7:0] TCSB_EXP_STATUS_RST = 8'h00;
   localparam logic [1:0] TCSB_INT_MASK_RST   = 2'h0;

   // Completion code that counts as an error besides the top half
   localparam logic [3:0] TCSB_CODE_BAD_CONFIRM = 4'h7;

   // Kind of frame that ended full confirmation
   typedef enum logic [1:0] {
      TCSB_KIND_OTHER      = 2'h0,
      TCSB_KIND_TOKEN      = 2'h1,
      TCSB_KIND_OTHER_VOID = 2'h2,
      TCSB_KIND_MY_VOID    = 2'h3
   } tcsb_kind_t;

   typedef enum logic [1:0] {
      TCSB_ST_IDLE    = 2'b01,
      TCSB_ST_CONFIRM = 2'b10
   } tcsb_state_t;

   // Start of a request's confirmation
   typedef struct packed {
      logic       start;
      logic       fullConfirm;
      logic [2:0] channel;
   } tcsb_req_t;

   // One returning frame fully seen
   typedef struct packed {
      logic       done;
      tcsb_kind_t kind;
      logic [7:0] status;
   } tcsb_frame_t;

   // Received byte stream, FC byte marked first, ED byte marked last
   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic [7:0] data;
      logic       parity;
   } tcsb_rx_t;

   // End of confirmation with its completion code
   typedef struct packed {
      logic       valid;
      logic [3:0] code;
   } tcsb_end_t;

   // Finished confirmation status byte
   typedef struct packed {
      logic       valid;
      logic [2:0] channel;
      logic [7:0] status;
   } tcsb_conf_t;

   // Nine codes: bad confirmation and the whole upper half
   function automatic logic tcsb_is_exception(input logic [3:0] code);
      return code[3] || (code == TCSB_CODE_BAD_CONFIRM);
   endfunction

   // Sticky bit update where a set beats a same-cycle clear
   function automatic logic [7:0] tcsb_sticky(input logic [7:0] old,
                                              input logic [7:0] set,
                                              input logic [7:0] clr);
      return (old & ~clr) | set;
   endfunction

endpackage

// ---- logic/tcsb_status_byte.sv ----
// Confirmation status byte builder with Avalon-MM registers and interrupt
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tcsb_status_byte
   import tcsb_pkg::*;
#(
   parameter int NUM_CHANNELS = 2,
   parameter bit ODD_PARITY   = 1'b1
) (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    reset,
   // Avalon-MM slave
   input  wire logic [2:0]              address,
   input  wire logic                    read,
   input  wire logic                    write,
   input  wire logic [3:0]              byteenable,
   input  wire logic [31:0]             writedata,
   output logic      [31:0]             readdata,
   output logic                         waitrequest,
   // Ring-side events
   input  wire tcsb_req_t               request,
   input  wire tcsb_frame_t             frame,
   input  wire tcsb_rx_t                rxByte,
   input  wire tcsb_end_t               confirmEnd,
   input  wire logic                    ringOperational,
   // Results
   output tcsb_conf_t                   confirmation,
   output logic      [NUM_CHANNELS-1:0] request_exception_attention,
   output logic                         confirmBusy,
   output logic                         irq
);

   // Channel numbers travel in three bits
   if (NUM_CHANNELS < 1 || NUM_CHANNELS > 8) begin : g_check
      $error("NUM_CHANNELS must lie between 1 and 8");
   end

   typedef struct packed {
      tcsb_state_t             st;
      logic [2:0]              chan;
      logic                    full;
      tcsb_kind_t              lastKind;
      logic                    unexp;
      logic                    parErr;
      logic                    ringAtStart;
      logic                    ringChg;
      logic                    inFrame;
      logic [7:0]              mode;
      logic [7:0]              expStatus;
      logic [7:0]              lastStatus;
      logic [NUM_CHANNELS-1:0] attn;
      logic [1:0]              intStatus;
      logic [1:0]              intMask;
      logic                    irq;
      tcsb_conf_t              conf;
      logic                    waitReq;
      logic [31:0]             readData;
   } tcsb_regs_t;

   tcsb_regs_t              r;
   tcsb_regs_t              next_r;

   logic                    confirming;
   logic                    thruParity;
   logic                    byteParErr;
   logic                    checkByte;
   logic                    frameUnexp;
   logic                    ringMoved;
   logic                    endNow;
   logic                    excNow;
   logic [7:0]              statusNow;
   logic [7:0]              attnSet;
   logic [7:0]              attnClr;
   logic [7:0]              intSet;
   logic [7:0]              intClr;
   logic [7:0]              attnWide;
   logic [7:0]              intWide;
   logic                    busWrite;
   logic                    lowLane;

   // Per-cycle event decode, shared by flags and registers
   always_comb begin
      confirming = (r.st == TCSB_ST_CONFIRM);
      thruParity = r.mode[TCSB_MODE_THRU_PARITY];
      // Byte is inside FC..ED when it opens a frame or one is open
      checkByte  = confirming && thruParity && rxByte.valid &&
                   (rxByte.first || r.inFrame);
      byteParErr = ODD_PARITY ? ~(^{rxByte.data, rxByte.parity})
                              : (^{rxByte.data, rxByte.parity});
      // Compare only while the request asked for full confirmation
      frameUnexp = confirming && r.full && frame.done &&
                   (frame.status != r.expStatus);
      ringMoved  = confirming &&
                   (ringOperational != r.ringAtStart);
      endNow     = confirming && confirmEnd.valid;
      excNow     = endNow && tcsb_is_exception(confirmEnd.code);
      // Events of the closing cycle are folded in, so none is lost
      statusNow = 8'h00;
      if (r.full) begin
         statusNow[TCSB_CS_KIND_LSB +: 2] =
            frame.done ? frame.kind : r.lastKind;
      end
      statusNow[TCSB_CS_FULL]   = r.full;
      statusNow[TCSB_CS_UNEXP]  = r.unexp || frameUnexp;
      statusNow[TCSB_CS_PARITY] = r.parErr ||
                                  (checkByte && byteParErr);
      statusNow[TCSB_CS_EXC]    = excNow;
      statusNow[TCSB_CS_RINGOP] = r.ringChg || ringMoved;
   end

   // Register bus decode: the access lands when waitrequest is low
   always_comb begin
      busWrite = write && !r.waitReq;
      lowLane  = byteenable[0];
      attnClr  = 8'h00;
      intClr   = 8'h00;
      if (busWrite && lowLane) begin
         if (address == TCSB_REG_ATTENTION) begin
            attnClr = writedata[7:0];
         end
         if (address == TCSB_REG_INT_STATUS) begin
            intClr = writedata[7:0];
         end
      end
      // Exception of a channel raises its attention bit
      attnSet = 8'h00;
      if (excNow) begin
         attnSet[r.chan] = 1'b1;
      end
      intSet = 8'h00;
      intSet[TCSB_INT_DONE] = endNow;
      intSet[TCSB_INT_EXC]  = excNow;
      attnWide = 8'h00;
      attnWide[NUM_CHANNELS-1:0] = r.attn;
      intWide = {6'h00, r.intStatus};
   end

   // Next-state logic for the whole block
   always_comb begin
      next_r = r;
      next_r.conf.valid = 1'b0;

      // Confirmation sequencing
      case (r.st)
         TCSB_ST_IDLE: begin
            // A new request clears every flag of the previous one
            if (request.start) begin
               next_r.st          = TCSB_ST_CONFIRM;
               next_r.chan        = request.channel;
               next_r.full        = request.fullConfirm;
               next_r.lastKind    = TCSB_KIND_OTHER;
               next_r.unexp       = 1'b0;
               next_r.parErr      = 1'b0;
               next_r.ringChg     = 1'b0;
               next_r.inFrame     = 1'b0;
               next_r.ringAtStart = ringOperational;
            end
         end
         TCSB_ST_CONFIRM: begin
            // Later request starts are ignored until the end
            if (frame.done) begin
               next_r.lastKind = frame.kind;
            end
            if (frameUnexp) begin
               next_r.unexp = 1'b1;
            end
            if (checkByte && byteParErr) begin
               next_r.parErr = 1'b1;
            end
            if (rxByte.valid) begin
               // ED byte closes the checked span
               if (rxByte.last) begin
                  next_r.inFrame = 1'b0;
               end else if (rxByte.first) begin
                  next_r.inFrame = 1'b1;
               end
            end
            if (ringMoved) begin
               next_r.ringChg = 1'b1;
            end
            if (endNow) begin
               next_r.st           = TCSB_ST_IDLE;
               next_r.lastStatus   = statusNow;
               next_r.conf.valid   = 1'b1;
               next_r.conf.channel = r.chan;
               next_r.conf.status  = statusNow;
            end
         end
         default: begin
            next_r.st = TCSB_ST_IDLE;
         end
      endcase

      // Sticky bits, set beating a same-cycle clear
      next_r.attn = NUM_CHANNELS'(tcsb_sticky(attnWide, attnSet,
                                              attnClr));
      next_r.intStatus = 2'(tcsb_sticky(intWide, intSet, intClr));

      // Writable control registers
      if (busWrite && lowLane) begin
         case (address)
            TCSB_REG_MODE: begin
               next_r.mode = writedata[7:0];
            end
            TCSB_REG_EXP_STATUS: begin
               next_r.expStatus = writedata[7:0];
            end
            TCSB_REG_INT_MASK: begin
               next_r.intMask = writedata[1:0];
            end
            default: begin
               next_r.mode = r.mode;
            end
         endcase
      end

      // Two-cycle handshake: read data is captured one cycle ahead
      if ((read || write) && r.waitReq) begin
         next_r.waitReq  = 1'b0;
         next_r.readData = 32'h0000_0000;
         if (read) begin
            case (address)
               TCSB_REG_MODE: begin
                  next_r.readData[7:0] = r.mode;
               end
               TCSB_REG_EXP_STATUS: begin
                  next_r.readData[7:0] = r.expStatus;
               end
               TCSB_REG_CONFIRM: begin
                  next_r.readData[7:0] = r.lastStatus;
                  next_r.readData[TCSB_CONFIRM_BUSY] = confirming;
               end
               TCSB_REG_ATTENTION: begin
                  next_r.readData[7:0] = attnWide;
               end
               TCSB_REG_INT_STATUS: begin
                  next_r.readData[1:0] = r.intStatus;
               end
               TCSB_REG_INT_MASK: begin
                  next_r.readData[1:0] = r.intMask;
               end
               default: begin
                  // Unmapped words read as zero
                  next_r.readData = 32'h0000_0000;
               end
            endcase
         end
      end else begin
         next_r.waitReq = 1'b1;
      end

      // Level interrupt, registered, from the next-state copies of status and mask
      next_r.irq = |(next_r.intStatus & next_r.intMask);
   end

   // State register
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         r.st          <= TCSB_ST_IDLE;
         r.chan        <= 3'h0;
         r.full        <= 1'b0;
         r.lastKind    <= TCSB_KIND_OTHER;
         r.unexp       <= 1'b0;
         r.parErr      <= 1'b0;
         r.ringAtStart <= 1'b0;
         r.ringChg     <= 1'b0;
         r.inFrame     <= 1'b0;
         r.mode        <= TCSB_MODE_RST;
         r.expStatus   <= TCSB_EXP_STATUS_RST;
         r.lastStatus  <= 8'h00;
         r.attn        <= '0;
         r.intStatus   <= 2'h0;
         r.intMask     <= TCSB_INT_MASK_RST;
         r.irq         <= 1'b0;
         r.conf        <= '0;
         r.waitReq     <= 1'b1;
         r.readData    <= 32'h0000_0000;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flops
   assign readdata                    = r.readData;
   assign waitrequest                 = r.waitReq;
   assign confirmation                = r.conf;
   assign request_exception_attention = r.attn;
   // One-hot code: bit 1 is the confirm state, so busy is a bare flop
   assign confirmBusy                 = r.st[1];
   assign irq                         = r.irq;

endmodule

// ---- tb/tcsb_host_model.sv ----
// Host memory that keeps the last confirmation word of each channel
`timescale 1ns/1ps
module tcsb_host_model
   import tcsb_pkg::*;
(
   // Clock
   input wire logic       ref_clk,
   // Confirmation words from the block
   input wire tcsb_conf_t confirmation
);
   logic [7:0] word [8];

   // Store each word as software would find it in memory
   always @(posedge ref_clk) begin
      if (confirmation.valid === 1'b1) begin
         word[confirmation.channel] <= confirmation.status;
      end
   end
endmodule

// ---- tb/tcsb_status_byte_chk.sv ----
// Port-level checks for the confirmation status byte block
`timescale 1ns/1ps
module tcsb_status_byte_chk
   import tcsb_pkg::*;
#(
   parameter int NUM_CHANNELS = 2
) (
   // Clock and reset
   input wire logic                    ref_clk,
   input wire logic                    reset,
   // Bus handshake
   input wire logic                    read,
   input wire logic                    write,
   input wire logic                    waitrequest,
   // Ring-side events
   input wire tcsb_req_t               request,
   input wire tcsb_end_t               confirmEnd,
   // Results
   input wire tcsb_conf_t              confirmation,
   input wire logic [NUM_CHANNELS-1:0] request_exception_attention,
   input wire logic                    confirmBusy
);
   logic       fullSeen;
   logic [2:0] chanSeen;

   // Remember what the accepted request asked for
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fullSeen <= 1'b0;
         chanSeen <= 3'h0;
      end else if (request.start && !confirmBusy) begin
         fullSeen <= request.fullConfirm;
         chanSeen <= request.channel;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_wait_answer: assert property ((read || write) && waitrequest
      |=> !waitrequest) else $error("no bus answer");
   chk_wait_pulse: assert property ($fell(waitrequest) |=> waitrequest)
      else $error("waitrequest low too long");
   chk_busy_start: assert property (!confirmBusy && request.start
      |=> confirmBusy) else $error("start not taken");
   chk_end_answer: assert property (confirmBusy && confirmEnd.valid
      |=> confirmation.valid && !confirmBusy) else $error("no result");
   chk_valid_pulse: assert property (confirmation.valid
      |=> !confirmation.valid) else $error("result pulse too long");
   chk_full_flag: assert property (confirmation.valid |->
      confirmation.status[2] == fullSeen && confirmation.channel == chanSeen)
      else $error("full flag or channel wrong");
   chk_partial_zero: assert property (confirmation.valid &&
      !confirmation.status[2] |-> confirmation.status[3:0] == 4'h0)
      else $error("kind or unexpected set without full");
   chk_exc_code: assert property (confirmBusy && confirmEnd.valid |=>
      confirmation.status[5] == ($past(confirmEnd.code) >= 4'h7))
      else $error("exception flag wrong");
   chk_exc_attn: assert property (confirmation.valid &&
      confirmation.status[5]
      |-> request_exception_attention[confirmation.channel])
      else $error("attention not raised");
   chk_top_zero: assert property (confirmation.valid
      |-> !confirmation.status[7]) else $error("spare bit set");

   cover property (confirmation.valid && confirmation.status[5]);
   cover property (confirmation.valid && confirmation.status[4]);
   cover property (confirmation.valid && confirmation.status[6]);
endmodule

bind tcsb_status_byte tcsb_status_byte_chk #(.NUM_CHANNELS(NUM_CHANNELS))
   u_chk (.ref_clk(ref_clk), .reset(reset), .read(read), .write(write),
   .waitrequest(waitrequest), .request(request), .confirmEnd(confirmEnd),
   .confirmation(confirmation), .confirmBusy(confirmBusy),
   .request_exception_attention(request_exception_attention));

// ---- tb/testbench.sv ----
// Self-checking bench for the confirmation status byte block
`timescale 1ns/1ps
module testbench;
   import tcsb_pkg::*;
   logic        ref_clk, reset, read, write, waitrequest, ringOperational;
   logic        confirmBusy, irq;
   logic [2:0]  address;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, rd;
   logic [1:0]  attn;
   tcsb_req_t   request;
   tcsb_frame_t frame;
   tcsb_rx_t    rxByte;
   tcsb_end_t   confirmEnd;
   tcsb_conf_t  confirmation;
   int          n_errors, compares, cycles;

   tcsb_status_byte #(.NUM_CHANNELS(2)) dut (.ref_clk(ref_clk),
      .reset(reset), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .request(request), .frame(frame),
      .rxByte(rxByte), .confirmEnd(confirmEnd),
      .ringOperational(ringOperational), .confirmation(confirmation),
      .request_exception_attention(attn), .confirmBusy(confirmBusy),
      .irq(irq));
   tcsb_host_model host (.ref_clk(ref_clk), .confirmation(confirmation));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Hang guard, far above the expected run length
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [2:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      @(posedge ref_clk);
      write <= wr;
      read <= !wr;
      address <= a;
      byteenable <= be;
      writedata <= d;
      // Only the bench timeout ends this wait
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // One request: two received bytes, one returning frame, then the end
   task automatic confirm(input logic full, input logic [2:0] ch,
      input logic [1:0] kind, input logic [7:0] fst, input logic badPar,
      input logic flip, input logic [3:0] code, input logic [7:0] exp);
      @(posedge ref_clk);
      request <= '{1'b1, full, ch};
      @(posedge ref_clk);
      request <= '0;
      rxByte <= '{1'b1, 1'b1, 1'b0, 8'h00, !badPar};
      @(posedge ref_clk);
      check({31'h0, confirmBusy}, 32'h1);
      rxByte <= '{1'b1, 1'b0, 1'b1, 8'h01, 1'b0};
      frame <= '{1'b1, tcsb_kind_t'(kind), fst};
      if (flip) ringOperational <= !ringOperational;
      @(posedge ref_clk);
      rxByte <= '0;
      frame <= '0;
      confirmEnd <= '{1'b1, code};
      @(posedge ref_clk);
      confirmEnd <= '0;
      // Only the bench timeout ends this wait
      while (confirmation.valid !== 1'b1) begin
         @(posedge ref_clk);
      end
      check({31'h0, confirmBusy}, 32'h0);
      check({24'h0, confirmation.status}, {24'h0, exp});
      check({29'h0, confirmation.channel}, {29'h0, ch});
      @(posedge ref_clk);
      check({24'h0, host.word[ch]}, {24'h0, exp});
      $display("confirmation test done");
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      {reset, read, write, address, byteenable, writedata} = '1;
      {read, write, address, byteenable, writedata} = '0;
      {request, frame, rxByte, confirmEnd} = '0;
      ringOperational = 1'b1;
      {n_errors, compares} = '0;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      // Reset values, unmapped index, ignored writes
      bus(0, TCSB_REG_MODE, 4'hf, 0);
      check(rd, 32'h0);
      bus(0, 3'h7, 4'hf, 0);
      check(rd, 32'h0);
      bus(1, TCSB_REG_EXP_STATUS, 4'h0, 32'hff);
      bus(1, TCSB_REG_EXP_STATUS, 4'h1, 32'h55);
      bus(0, TCSB_REG_EXP_STATUS, 4'hf, 0);
      check(rd, 32'h55);
      bus(1, TCSB_REG_MODE, 4'h1, 1);
      bus(1, TCSB_REG_INT_MASK, 4'h1, 3);
      $display("register test done");
      // Full, token, unexpected status, exception code
      confirm(1, 1, 2'h1, 8'h12, 0, 0, 4'h8, 8'h2d);
      check({31'h0, irq}, 32'h1);
      check({30'h0, attn}, 32'h2);
      bus(0, TCSB_REG_ATTENTION, 4'hf, 0);
      check(rd, 32'h2);
      bus(0, TCSB_REG_CONFIRM, 4'hf, 0);
      check(rd, 32'h2d);
      bus(1, TCSB_REG_ATTENTION, 4'h1, 2);
      bus(1, TCSB_REG_INT_STATUS, 4'h1, 3);
      bus(0, TCSB_REG_ATTENTION, 4'hf, 0);
      check(rd, 32'h0);
      check({31'h0, irq}, 32'h0);
      // Not full: no kind, no unexpected; parity and ring change
      confirm(0, 0, 2'h3, 8'h12, 1, 1, 4'h0, 8'h50);
      bus(0, TCSB_REG_INT_STATUS, 4'hf, 0);
      check(rd, 32'h1);
      bus(1, TCSB_REG_INT_STATUS, 4'h1, 1);
      // Parity check off: bad byte leaves no mark
      bus(1, TCSB_REG_MODE, 4'h1, 0);
      confirm(1, 0, 2'h3, 8'h55, 1, 0, 4'h7, 8'h27);
      bus(0, TCSB_REG_ATTENTION, 4'hf, 0);
      check(rd, 32'h1);
      confirm(1, 1, 2'h2, 8'h55, 0, 0, 4'h1, 8'h06);
      confirm(1, 1, 2'h0, 8'h55, 0, 0, 4'h6, 8'h04);
      close_out();
   end
endmodule
